//--- common/stb_pkg.sv
// constants, field layouts and enumerations of the 16-bit timer block
// assumes an 8-bit cpu register port with byte addresses 0x0 to 0xb
package stb_pkg;

  localparam int unsigned STB_AW = 4;
  localparam int unsigned STB_DW = 8;
  localparam int unsigned STB_CW = 16;

  // byte register addresses
  localparam logic [3:0] STB_A_CTRL_A = 4'h0;
  localparam logic [3:0] STB_A_CTRL_B = 4'h1;
  localparam logic [3:0] STB_A_CNT_LO = 4'h2;
  localparam logic [3:0] STB_A_CNT_HI = 4'h3;
  localparam logic [3:0] STB_A_CMPA_LO = 4'h4;
  localparam logic [3:0] STB_A_CMPA_HI = 4'h5;
  localparam logic [3:0] STB_A_CMPB_LO = 4'h6;
  localparam logic [3:0] STB_A_CMPB_HI = 4'h7;
  localparam logic [3:0] STB_A_CAP_LO = 4'h8;
  localparam logic [3:0] STB_A_CAP_HI = 4'h9;
  localparam logic [3:0] STB_A_FLAG = 4'ha;
  localparam logic [3:0] STB_A_MASK = 4'hb;

  // control a fields
  localparam int unsigned STB_CA_OMA_LSB = 0;
  localparam int unsigned STB_CA_OMB_LSB = 2;
  localparam int unsigned STB_CA_CAP_SRC = 6;
  // control b fields
  localparam int unsigned STB_CB_CS_LSB = 0;
  localparam int unsigned STB_CB_EDGE = 3;
  localparam int unsigned STB_CB_TOP_LSB = 4;
  localparam int unsigned STB_CB_FILT = 7;

  // flag and mask bit positions
  localparam int unsigned STB_F_OVF = 0;
  localparam int unsigned STB_F_MA = 1;
  localparam int unsigned STB_F_MB = 2;
  localparam int unsigned STB_F_CAP = 3;
  localparam int unsigned STB_NFLAG = 4;

  typedef enum logic [2:0] {
    STB_CS_OFF = 3'h0,
    STB_CS_DIV1 = 3'h1,
    STB_CS_DIV8 = 3'h2,
    STB_CS_DIV64 = 3'h3,
    STB_CS_DIV256 = 3'h4,
    STB_CS_DIV1024 = 3'h5,
    STB_CS_EXT_FALL = 3'h6,
    STB_CS_EXT_RISE = 3'h7
  } stb_cs_t;

  typedef enum logic [2:0] {
    STB_TOP_MAX = 3'h0,
    STB_TOP_8 = 3'h1,
    STB_TOP_9 = 3'h2,
    STB_TOP_10 = 3'h3,
    STB_TOP_CMPA = 3'h4,
    STB_TOP_CAP = 3'h5
  } stb_top_t;

  typedef enum logic [1:0] {
    STB_OM_OFF = 2'h0,
    STB_OM_TOGGLE = 2'h1,
    STB_OM_PWM = 2'h2,
    STB_OM_PWM_INV = 2'h3
  } stb_om_t;

  localparam logic [15:0] STB_BOTTOM = 16'h0000;
  localparam logic [15:0] STB_MAX = 16'hffff;
  localparam logic [15:0] STB_TOP8_VAL = 16'h00ff;
  localparam logic [15:0] STB_TOP9_VAL = 16'h01ff;
  localparam logic [15:0] STB_TOP10_VAL = 16'h03ff;
  localparam logic [15:0] STB_ONE = 16'h0001;

  // prescaler width and terminal masks
  localparam int unsigned STB_PS_W = 10;
  localparam logic [9:0] STB_PS_M8 = 10'h007;
  localparam logic [9:0] STB_PS_M64 = 10'h03f;
  localparam logic [9:0] STB_PS_M256 = 10'h0ff;
  localparam logic [9:0] STB_PS_M1024 = 10'h3ff;
  localparam logic [9:0] STB_PS_ONE = 10'h001;

  localparam int unsigned STB_FILT_LEN = 4;
  localparam logic [7:0] STB_RST_BYTE = 8'h00;
  localparam logic [15:0] STB_RST_WORD = 16'h0000;
  localparam logic [3:0] STB_RST_FLAGS = 4'h0;

endpackage

//--- common/stb_cap_if.sv
// capture path signals between the timer core and its input filter
// assumes both ends run on the same core clock
`timescale 1ns/1ps
interface stb_cap_if;
  logic pin_raw;
  logic cmp_raw;
  logic src_cmp;
  logic filt_en;
  logic rise_edge;
  logic event_p;
  modport filt (input pin_raw, input cmp_raw, input src_cmp, input filt_en,
    input rise_edge, output event_p);
  modport ctl (output pin_raw, output cmp_raw, output src_cmp, output filt_en,
    output rise_edge, input event_p);
endinterface

//--- verilog/stb_cap_filter.sv
// capture input synchroniser, noise filter and edge detector
// assumes raw pin and comparator levels are asynchronous to core_clk_in
`timescale 1ns/1ps
module stb_cap_filter
  import stb_pkg::*;
#(
  parameter int unsigned LEN = STB_FILT_LEN
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  stb_cap_if.filt cap
);

  logic pin_s1_q, pin_s2_q, cmp_s1_q, cmp_s2_q;
  logic [LEN-1:0] hist_q;
  logic level_q, event_q;
  wire logic sel_w = cap.src_cmp ? cmp_s2_q : pin_s2_q;
  wire logic all_one_w = &hist_q;
  wire logic all_zero_w = ~|hist_q;
  // with the filter enabled, filtered level moves only after LEN equal samples
  wire logic level_d = !cap.filt_en ? sel_w :
    all_one_w ? 1'b1 : all_zero_w ? 1'b0 : level_q; // R11
  wire logic event_d = (level_d != level_q) && (level_d == cap.rise_edge); // R10

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
      hist_q <= '0;
      level_q <= 1'b0;
      event_q <= 1'b0;
    end else begin
      pin_s1_q <= cap.pin_raw;
      pin_s2_q <= pin_s1_q;
      cmp_s1_q <= cap.cmp_raw;
      cmp_s2_q <= cmp_s1_q;
      hist_q <= {hist_q[LEN-2:0], sel_w};
      level_q <= level_d;
      event_q <= event_d;
    end
  end

  assign cap.event_p = event_q;

  chk_filter_steady_high: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    ($past(cap.filt_en) && $rose(level_q)) |-> $past(all_one_w)) // R11
    else $error("filtered level rose without a steady run of ones");

  chk_edge_polarity: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    event_q |-> (level_q == $past(cap.rise_edge) && level_q != $past(level_q))) // R10
    else $error("capture event on the wrong edge");

endmodule

//--- verilog/stb_timer.sv
// 16-bit timer/counter with two compare channels, capture and byte access
// assumes a cpu master on core_clk_in: one-cycle strobes, read data next cycle
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
// Operation
// R01: four maskable sources: overflow, match a, match b, capture.
// R02: software clears the power off input before the timer runs.
// R03: counter, both compares and capture are 16 bits, byte accessed.
// R04: two 8-bit control registers read and write freely.
// R05: each source shows a flag, gated by its own mask bit.
// R06: tick comes from prescaler or external pin, source and edge selectable.
// R07: with no clock selected the counter holds its value.
// R08: buffered compares match counter continuously and set their flags.
// R09: matches drive a waveform onto each compare output.
// R10: an edge on pin or comparator copies counter into capture.
// R11: capture path has an enable-able noise filter.
// R12: top is 0x00ff, 0x01ff, 0x03ff, compare a or capture by mode.
// R13: compare a as pwm top gives no a output, top double buffered.
// R14: bottom is 0x0000 and max is 0xffff.
// R15: one shared 8-bit high byte holding register.
// R16: low byte write loads held high and low byte together.
// R17: low byte read copies high byte to holding; high read returns it.
// R18: compare reads bypass the holding register.
// R19: cpu writes high then low, reads low then high.
// R20: main code masks interrupts around two-byte accesses.
// R21: cpu counter write beats clear or count in the same cycle.
// R22: capture flag sets in the cycle the capture register loads.
// R23: high byte write touches only the holding register.
module stb_timer
  import stb_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic [STB_AW-1:0] addr_in,
  input wire logic [STB_DW-1:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [STB_DW-1:0] rd_data_out,
  input wire logic timer_power_off_in,
  input wire logic external_count_pin_in,
  input wire logic capture_pin_in,
  input wire logic analog_cmp_in,
  output logic compare_out_a_out,
  output logic compare_out_b_out,
  output logic [STB_NFLAG-1:0] irq_req_out
);

  logic [7:0] ctrl_a_q, ctrl_b_q, temp_q, rd_data_q;
  logic [15:0] count_q, cmpa_buf_q, cmpb_buf_q, cmpa_act_q, cmpb_act_q, cap_q;
  logic [STB_NFLAG-1:0] flags_q, mask_q, irq_q;
  logic [STB_PS_W-1:0] ps_q;
  logic ext_s1_q, ext_s2_q, ext_s3_q;
  logic out_a_q, out_b_q;

  stb_cap_if cap_bus();

  stb_cap_filter #(.LEN(STB_FILT_LEN)) u_filter (
    .core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in),
    .cap(cap_bus)
  );

  // control fields
  wire stb_cs_t cs_w = stb_cs_t'(ctrl_b_q[STB_CB_CS_LSB +: 3]);
  wire stb_top_t top_sel_w = stb_top_t'(ctrl_b_q[STB_CB_TOP_LSB +: 3]);
  wire stb_om_t om_a_w = stb_om_t'(ctrl_a_q[STB_CA_OMA_LSB +: 2]);
  wire stb_om_t om_b_w = stb_om_t'(ctrl_a_q[STB_CA_OMB_LSB +: 2]);

  assign cap_bus.pin_raw = capture_pin_in;
  assign cap_bus.cmp_raw = analog_cmp_in;
  assign cap_bus.src_cmp = ctrl_a_q[STB_CA_CAP_SRC];
  assign cap_bus.filt_en = ctrl_b_q[STB_CB_FILT];
  assign cap_bus.rise_edge = ctrl_b_q[STB_CB_EDGE];

  // address decode
  wire logic wr_ctrl_a_w = wr_en_in && addr_in == STB_A_CTRL_A;
  wire logic wr_ctrl_b_w = wr_en_in && addr_in == STB_A_CTRL_B;
  wire logic wr_cnt_lo_w = wr_en_in && addr_in == STB_A_CNT_LO;
  wire logic wr_cmpa_lo_w = wr_en_in && addr_in == STB_A_CMPA_LO;
  wire logic wr_cmpb_lo_w = wr_en_in && addr_in == STB_A_CMPB_LO;
  wire logic wr_cap_lo_w = wr_en_in && addr_in == STB_A_CAP_LO;
  wire logic wr_flag_w = wr_en_in && addr_in == STB_A_FLAG;
  wire logic wr_mask_w = wr_en_in && addr_in == STB_A_MASK;
  wire logic wr_hi_w = wr_en_in && (addr_in == STB_A_CNT_HI || addr_in == STB_A_CMPA_HI ||
    addr_in == STB_A_CMPB_HI || addr_in == STB_A_CAP_HI);
  wire logic rd_cnt_lo_w = rd_en_in && addr_in == STB_A_CNT_LO;
  wire logic rd_cap_lo_w = rd_en_in && addr_in == STB_A_CAP_LO;
  wire logic [15:0] wr_word_w = {temp_q, wr_data_in}; // R16

  // timer tick selection; power off stops every tick
  wire logic ext_rise_w = ext_s2_q && !ext_s3_q;
  wire logic ext_fall_w = !ext_s2_q && ext_s3_q;
  logic tick_sel_w;
  always_comb begin
    case (cs_w) // R06
      STB_CS_OFF: tick_sel_w = 1'b0; // R07
      STB_CS_DIV1: tick_sel_w = 1'b1;
      STB_CS_DIV8: tick_sel_w = (ps_q & STB_PS_M8) == STB_PS_M8;
      STB_CS_DIV64: tick_sel_w = (ps_q & STB_PS_M64) == STB_PS_M64;
      STB_CS_DIV256: tick_sel_w = (ps_q & STB_PS_M256) == STB_PS_M256;
      STB_CS_DIV1024: tick_sel_w = (ps_q & STB_PS_M1024) == STB_PS_M1024;
      STB_CS_EXT_FALL: tick_sel_w = ext_fall_w;
      STB_CS_EXT_RISE: tick_sel_w = ext_rise_w;
      default: tick_sel_w = 1'b0;
    endcase
  end
  wire logic tick_w = tick_sel_w && !timer_power_off_in; // R02

  // top selection and counting
  wire logic [15:0] top_w = (top_sel_w == STB_TOP_8) ? STB_TOP8_VAL :
    (top_sel_w == STB_TOP_9) ? STB_TOP9_VAL :
    (top_sel_w == STB_TOP_10) ? STB_TOP10_VAL :
    (top_sel_w == STB_TOP_CMPA) ? cmpa_act_q :
    (top_sel_w == STB_TOP_CAP) ? cap_q : STB_MAX; // R12
  // a cpu counter low byte write removes any count, wrap or match of that cycle
  wire logic run_w = tick_w && !wr_cnt_lo_w; // R21
  wire logic wrap_w = run_w && count_q == top_w;
  wire logic [15:0] count_d = wr_cnt_lo_w ? wr_word_w : // R21
    wrap_w ? STB_BOTTOM : run_w ? count_q + STB_ONE : count_q; // R14
  wire logic match_a_w = run_w && count_q == cmpa_act_q; // R08
  wire logic match_b_w = run_w && count_q == cmpb_act_q; // R08
  // in every top mode but STB_TOP_MAX the active compare only moves at the wrap
  wire logic load_act_w = (top_sel_w == STB_TOP_MAX) || wrap_w; // R13

  // capture is off while the capture register defines top
  wire logic cap_ev_w = cap_bus.event_p && top_sel_w != STB_TOP_CAP; // R10
  wire logic cap_wr_w = wr_cap_lo_w && top_sel_w == STB_TOP_CAP;

  function automatic logic wave_next(input stb_om_t om, input logic cur,
      input logic match, input logic wrap);
    logic nxt;
    nxt = 1'b0;
    case (om)
      STB_OM_OFF: nxt = 1'b0;
      STB_OM_TOGGLE: nxt = match ? !cur : cur;
      STB_OM_PWM: nxt = wrap ? 1'b1 : match ? 1'b0 : cur;
      STB_OM_PWM_INV: nxt = wrap ? 1'b0 : match ? 1'b1 : cur;
      default: nxt = 1'b0;
    endcase
    return nxt;
  endfunction

  wire logic a_is_top_pwm_w = top_sel_w == STB_TOP_CMPA &&
    (om_a_w == STB_OM_PWM || om_a_w == STB_OM_PWM_INV);
  wire logic out_a_d = a_is_top_pwm_w ? 1'b0 : // R13
    wave_next(om_a_w, out_a_q, match_a_w, wrap_w); // R09
  wire logic out_b_d = wave_next(om_b_w, out_b_q, match_b_w, wrap_w); // R09

  // flags: hardware set wins over a software clear in the same cycle
  wire logic [STB_NFLAG-1:0] flag_set_w = {cap_ev_w, match_b_w, match_a_w, wrap_w}; // R01
  wire logic [STB_NFLAG-1:0] flag_clr_w = wr_flag_w ? wr_data_in[STB_NFLAG-1:0] : '0;
  wire logic [STB_NFLAG-1:0] flags_d = flag_set_w | (flags_q & ~flag_clr_w); // R05

  // shared high byte holding register
  wire logic [7:0] temp_d = wr_hi_w ? wr_data_in : // R23
    rd_cnt_lo_w ? count_q[15:8] : // R17
    rd_cap_lo_w ? cap_q[15:8] : temp_q; // R15

  // read selection; upper flag and mask bits read as zero
  wire logic [7:0] rd_mux_w =
    (addr_in == STB_A_CTRL_A) ? ctrl_a_q :
    (addr_in == STB_A_CTRL_B) ? ctrl_b_q :
    (addr_in == STB_A_CNT_LO) ? count_q[7:0] :
    (addr_in == STB_A_CNT_HI) ? temp_q : // R17
    (addr_in == STB_A_CMPA_LO) ? cmpa_buf_q[7:0] :
    (addr_in == STB_A_CMPA_HI) ? cmpa_buf_q[15:8] : // R18
    (addr_in == STB_A_CMPB_LO) ? cmpb_buf_q[7:0] :
    (addr_in == STB_A_CMPB_HI) ? cmpb_buf_q[15:8] : // R18
    (addr_in == STB_A_CAP_LO) ? cap_q[7:0] :
    (addr_in == STB_A_CAP_HI) ? temp_q :
    (addr_in == STB_A_FLAG) ? {4'h0, flags_q} :
    (addr_in == STB_A_MASK) ? {4'h0, mask_q} : STB_RST_BYTE;

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_a_q <= STB_RST_BYTE;
      ctrl_b_q <= STB_RST_BYTE;
      mask_q <= STB_RST_FLAGS;
    end else begin
      if (wr_ctrl_a_w) begin
        ctrl_a_q <= wr_data_in; // R04
      end
      if (wr_ctrl_b_w) begin
        ctrl_b_q <= wr_data_in; // R04
      end
      if (wr_mask_w) begin
        mask_q <= wr_data_in[STB_NFLAG-1:0]; // R05
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count_q <= STB_RST_WORD;
      temp_q <= STB_RST_BYTE;
      ps_q <= '0;
    end else begin
      count_q <= count_d; // R03
      temp_q <= temp_d;
      ps_q <= timer_power_off_in ? ps_q : ps_q + STB_PS_ONE;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cmpa_buf_q <= STB_RST_WORD;
      cmpb_buf_q <= STB_RST_WORD;
      cmpa_act_q <= STB_RST_WORD;
      cmpb_act_q <= STB_RST_WORD;
    end else begin
      if (wr_cmpa_lo_w) begin
        cmpa_buf_q <= wr_word_w; // R16
      end
      if (wr_cmpb_lo_w) begin
        cmpb_buf_q <= wr_word_w; // R16
      end
      if (load_act_w) begin
        cmpa_act_q <= cmpa_buf_q; // R13
        cmpb_act_q <= cmpb_buf_q;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cap_q <= STB_RST_WORD;
      flags_q <= STB_RST_FLAGS;
    end else begin
      if (cap_ev_w) begin
        cap_q <= count_q; // R10
      end else if (cap_wr_w) begin
        cap_q <= wr_word_w;
      end
      flags_q <= flags_d; // R22
    end
  end

  // external count pin crosses in through two flops before the edge detector
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= external_count_pin_in;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      out_a_q <= 1'b0;
      out_b_q <= 1'b0;
      irq_q <= STB_RST_FLAGS;
      rd_data_q <= STB_RST_BYTE;
    end else begin
      out_a_q <= out_a_d;
      out_b_q <= out_b_d;
      irq_q <= flags_q & mask_q; // R05
      rd_data_q <= rd_en_in ? rd_mux_w : STB_RST_BYTE;
    end
  end

  assign rd_data_out = rd_data_q;
  assign compare_out_a_out = out_a_q;
  assign compare_out_b_out = out_b_q;
  assign irq_req_out = irq_q;

  chk_low_write_load: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // R16
    wr_cnt_lo_w |=> count_q == {$past(temp_q), $past(wr_data_in)})
    else $error("counter low write did not load held high byte");

  chk_high_write_only: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // R23
    (wr_en_in && addr_in == STB_A_CMPA_HI) |=> ($stable(cmpa_buf_q) && temp_q == $past(wr_data_in)))
    else $error("high byte write changed a compare register");

  chk_low_read_latch: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // R17
    rd_cnt_lo_w ##1 (rd_en_in && addr_in == STB_A_CNT_HI) |=> rd_data_q == $past(temp_q, 1) &&
    rd_data_q == $past(count_q[15:8], 2))
    else $error("high byte read did not return latched counter byte");

  chk_cmp_read_direct: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // R18
    (rd_en_in && addr_in == STB_A_CMPB_HI) |=> rd_data_q == $past(cmpb_buf_q[15:8]))
    else $error("compare high read went through the holding register");

  chk_idle_stop: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // R07
    (cs_w == STB_CS_OFF && !wr_cnt_lo_w) [*2] |-> $stable(count_q))
    else $error("counter moved with no clock selected");

  chk_capture_flag: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // R22
    cap_ev_w |=> (flags_q[STB_F_CAP] && cap_q == $past(count_q)))
    else $error("capture flag and capture value out of step");

  chk_match_flag: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // R08
    (run_w && count_q == cmpa_act_q) |=> flags_q[STB_F_MA])
    else $error("compare a match did not set its flag");

  chk_top_wrap: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // R12
    (run_w && top_sel_w == STB_TOP_8 && count_q == STB_TOP8_VAL) |=>
    (count_q == STB_BOTTOM && flags_q[STB_F_OVF]))
    else $error("counter did not wrap at fixed top");

  chk_irq_gate: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // R05
    (!mask_q[STB_F_MB] && !wr_mask_w) |=> !irq_q[STB_F_MB])
    else $error("masked source raised a request");

  chk_ctrl_rw: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // R04
    wr_ctrl_b_w ##1 (rd_en_in && addr_in == STB_A_CTRL_B && !wr_en_in) |=>
    rd_data_q == $past(wr_data_in, 2))
    else $error("control register read back differs from write");

  chk_top_a_silent: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // R13
    a_is_top_pwm_w |=> !compare_out_a_out)
    else $error("channel a drove pwm while used as top");

endmodule

//--- verif/stb_cpu_model.sv
// cpu model driving the timer's byte register port
// assumes each call starts just after a rising edge of core_clk_in
`timescale 1ns/1ps
module stb_cpu_model
  import stb_pkg::*;
(
  input wire logic core_clk_in,
  output logic [STB_AW-1:0] addr_out,
  output logic [STB_DW-1:0] wr_data_out,
  output logic wr_en_out,
  output logic rd_en_out,
  input wire logic [STB_DW-1:0] rd_data_in
);
  initial begin
    addr_out = 4'h0;
    wr_data_out = 8'h00;
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
  end
  // strobes drop and the data lines show the inverse, so a stale value never looks valid
  task automatic idle(input int n);
    wr_en_out <= 1'b0;
    rd_en_out <= 1'b0;
    wr_data_out <= ~wr_data_out;
    repeat (n) @(posedge core_clk_in);
  endtask
  // strobe left high; the next rd or idle lowers it, so writes run back to back
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr_out <= a;
    wr_data_out <= d;
    wr_en_out <= 1'b1;
    rd_en_out <= 1'b0;
    @(posedge core_clk_in);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    addr_out <= a;
    wr_en_out <= 1'b0;
    rd_en_out <= 1'b1;
    @(posedge core_clk_in);
    rd_en_out <= 1'b0;
    @(negedge core_clk_in);
    d = rd_data_in;
    @(posedge core_clk_in);
  endtask
  // single caller, so no handler can slip between the two bytes
  task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
    wr(lo + 4'h1, v[15:8]);
    wr(lo, v[7:0]);
  endtask
  task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
    rd(lo, v[7:0]);
    rd(lo + 4'h1, v[15:8]);
  endtask
endmodule

//--- verif/stb_timer_bench.sv
// self-checking bench of the 16-bit timer through its byte register port
// assumes the cpu model on the bus and pins driven here
`timescale 1ns/1ps
module stb_timer_bench
  import stb_pkg::*;
;
  logic clk, rst_b, pwr_off, ext_pin, cap_pin, acmp, out_a, out_b, wr_en, rd_en;
  logic [3:0] addr, irq;
  logic [7:0] wdat, rdat, b;
  logic [15:0] w, r;
  logic [31:0] seed = 32'hd2a41a60;
  logic sa, sb0, sb1;
  int fail_count = 0, cmp_count = 0, n;

  stb_cpu_model cpu (.core_clk_in(clk), .addr_out(addr), .wr_data_out(wdat),
    .wr_en_out(wr_en), .rd_en_out(rd_en), .rd_data_in(rdat));
  stb_timer dut (.core_clk_in(clk), .rst_b_in(rst_b), .addr_in(addr), .wr_data_in(wdat),
    .wr_en_in(wr_en), .rd_en_in(rd_en), .rd_data_out(rdat), .timer_power_off_in(pwr_off),
    .external_count_pin_in(ext_pin), .capture_pin_in(cap_pin), .analog_cmp_in(acmp),
    .compare_out_a_out(out_a), .compare_out_b_out(out_b), .irq_req_out(irq));

  function automatic logic [15:0] rnd16();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  function automatic logic [15:0] top_of(input int t);
    case (t)
      1: return STB_TOP8_VAL;
      2: return STB_TOP9_VAL;
      3: return STB_TOP10_VAL;
      default: return STB_MAX;
    endcase
  endfunction
  function automatic int div_of(input int m);
    return (m == 2) ? 8 : (m == 3) ? 64 : (m == 4) ? 256 : 1024;
  endfunction

  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    check16({8'h00, got}, {8'h00, exp});
  endtask
  task automatic check1(input logic got, input logic exp);
    check16({15'h0, got}, {15'h0, exp});
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    results();
  end

  initial begin
    rst_b = 1'b0;
    pwr_off = 1'b0;
    ext_pin = 1'b0;
    cap_pin = 1'b0;
    acmp = 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 16; a++) begin
      cpu.rd(4'(a), b);
      check8(b, 8'h00);
    end
    cpu.wr(4'hd, 8'h5a);
    cpu.rd(4'hd, b);
    check8(b, 8'h00);
    w = rnd16();
    cpu.wr(STB_A_CTRL_A, w[7:0] & 8'h4f);
    cpu.wr(STB_A_CTRL_B, w[15:8] & 8'hf8);
    cpu.rd(STB_A_CTRL_B, b);
    check8(b, w[15:8] & 8'hf8);
    cpu.rd(STB_A_CTRL_A, b);
    check8(b, w[7:0] & 8'h4f);
    cpu.wr(STB_A_CTRL_B, 8'h00);
    done("reset and control");
    for (int i = 0; i < 4; i++) begin
      w = (i == 0) ? STB_MAX : (i == 1) ? STB_BOTTOM : rnd16();
      // random pin noise while no clock is selected must not move the counter
      ext_pin <= w[0];
      pwr_off <= w[1] & (i < 3);
      cpu.wr16(STB_A_CNT_LO, w);
      cpu.idle(5);
      cpu.rd16(STB_A_CNT_LO, r);
      check16(r, w);
    end
    cpu.wr(STB_A_CNT_HI, ~w[15:8]);
    cpu.rd16(STB_A_CNT_LO, r);
    check16(r, w);
    w = rnd16();
    cpu.wr16(STB_A_CMPB_LO, ~w);
    cpu.wr16(STB_A_CMPA_LO, w);
    cpu.wr(STB_A_CNT_LO, 8'h00);
    cpu.rd(STB_A_CMPB_HI, b);
    check8(b, ~w[15:8]);
    cpu.wr(STB_A_CNT_HI, ~w[15:8]);
    cpu.rd(STB_A_CMPA_HI, b);
    check8(b, w[15:8]);
    cpu.rd(STB_A_CMPA_LO, b);
    check8(b, w[7:0]);
    cpu.rd16(STB_A_CNT_LO, r);
    check16(r, {w[15:8], 8'h00});
    w = rnd16();
    cpu.wr16(STB_A_CAP_LO, w);
    cpu.rd16(STB_A_CAP_LO, r);
    check16(r, 16'h0000);
    cpu.wr(STB_A_CTRL_B, 8'h50);
    cpu.wr16(STB_A_CAP_LO, w);
    cpu.rd16(STB_A_CAP_LO, r);
    check16(r, w);
    done("byte access");
    cpu.wr(STB_A_CTRL_B, 8'h01);
    w = rnd16();
    cpu.wr16(STB_A_CNT_LO, w);
    cpu.rd(STB_A_CNT_LO, b);
    check8(b, w[7:0]);
    pwr_off <= 1'b1;
    w = rnd16();
    cpu.wr16(STB_A_CNT_LO, w);
    cpu.idle(20);
    cpu.rd16(STB_A_CNT_LO, r);
    check16(r, w);
    pwr_off <= 1'b0;
    cpu.idle(10);
    cpu.rd16(STB_A_CNT_LO, r);
    check1(r !== w, 1'b1);
    // stop the divide-by-one clock so it adds no tick to the first loop
    cpu.wr(STB_A_CTRL_B, 8'h00);
    for (int m = 2; m < 6; m++) begin
      cpu.wr16(STB_A_CNT_LO, 16'h0000);
      cpu.wr(STB_A_CTRL_B, 8'(m));
      cpu.idle(4 * div_of(m));
      cpu.wr(STB_A_CTRL_B, 8'h00);
      cpu.rd16(STB_A_CNT_LO, r);
      check1(r >= 16'h0004 && r <= 16'h0005, 1'b1);
    end
    for (int m = 6; m < 8; m++) begin
      cpu.wr16(STB_A_CNT_LO, 16'h0000);
      cpu.wr(STB_A_CTRL_B, 8'(m));
      cpu.idle(2);
      repeat (5) begin
        ext_pin <= 1'b1;
        cpu.idle(4);
        ext_pin <= 1'b0;
        cpu.idle(4);
      end
      cpu.idle(6);
      cpu.wr(STB_A_CTRL_B, 8'h00);
      cpu.rd16(STB_A_CNT_LO, r);
      check16(r, 16'h0005);
    end
    for (int t = 0; t < 4; t++) begin
      cpu.wr(STB_A_FLAG, 8'h0f);
      cpu.wr16(STB_A_CNT_LO, top_of(t) - 16'h0002);
      cpu.wr(STB_A_CTRL_B, 8'(t * 16 + 1));
      cpu.idle(8);
      cpu.wr(STB_A_CTRL_B, 8'h00);
      cpu.rd16(STB_A_CNT_LO, r);
      check1(r < 16'h0010, 1'b1);
      cpu.rd(STB_A_FLAG, b);
      check1(b[STB_F_OVF], 1'b1);
    end
    done("clock and top");
    cpu.wr16(STB_A_CMPA_LO, 16'h0010);
    cpu.wr16(STB_A_CMPB_LO, 16'h0020);
    cpu.wr16(STB_A_CNT_LO, 16'h0000);
    cpu.wr(STB_A_FLAG, 8'h0f);
    cpu.wr(STB_A_CTRL_B, 8'h01);
    cpu.idle(40);
    cpu.wr(STB_A_CTRL_B, 8'h00);
    cpu.rd(STB_A_FLAG, b);
    check8(b, 8'h06);
    check8({4'h0, irq}, 8'h00);
    cpu.wr(STB_A_MASK, 8'h02);
    cpu.idle(3);
    check8({4'h0, irq}, 8'h02);
    cpu.wr(STB_A_MASK, 8'h0f);
    cpu.wr(STB_A_FLAG, 8'h02);
    cpu.idle(3);
    check8({4'h0, irq}, 8'h04);
    cpu.wr(STB_A_MASK, 8'h00);
    done("flags");
    cpu.wr(STB_A_CTRL_A, 8'h00);
    cpu.wr(STB_A_CTRL_B, 8'h08);
    w = rnd16();
    acmp <= w[0];
    cpu.wr16(STB_A_CNT_LO, w);
    cpu.wr(STB_A_FLAG, 8'h0f);
    cap_pin <= 1'b1;
    cpu.idle(12);
    cpu.rd16(STB_A_CAP_LO, r);
    check16(r, w);
    cpu.rd(STB_A_FLAG, b);
    check1(b[STB_F_CAP], 1'b1);
    cap_pin <= 1'b0;
    acmp <= 1'b0;
    cpu.wr(STB_A_CTRL_A, 8'h40);
    cpu.wr(STB_A_CTRL_B, 8'h88);
    w = rnd16();
    cpu.wr16(STB_A_CNT_LO, w);
    cpu.wr(STB_A_FLAG, 8'h0f);
    acmp <= 1'b1;
    cpu.idle(1);
    acmp <= 1'b0;
    cpu.idle(12);
    cpu.rd(STB_A_FLAG, b);
    check1(b[STB_F_CAP], 1'b0);
    acmp <= 1'b1;
    cpu.idle(14);
    cpu.rd16(STB_A_CAP_LO, r);
    check16(r, w);
    done("capture");
    cpu.wr(STB_A_CTRL_A, 8'h0a);
    cpu.wr16(STB_A_CMPA_LO, 16'h0020);
    cpu.wr16(STB_A_CMPB_LO, 16'h0010);
    cpu.wr16(STB_A_CNT_LO, 16'h0000);
    cpu.wr(STB_A_CTRL_B, 8'h41);
    cpu.idle(1);
    {sa, sb0, sb1} = 3'b000;
    repeat (200) begin
      @(negedge clk);
      sa |= (out_a === 1'b1);
      sb1 |= (out_b === 1'b1);
      sb0 |= (out_b === 1'b0);
    end
    check1(sa, 1'b0);
    check1(sb0 & sb1, 1'b1);
    @(posedge clk);
    cpu.wr(STB_A_CTRL_A, 8'h01);
    cpu.wr(STB_A_CTRL_B, 8'h11);
    cpu.idle(1);
    n = 0;
    sa = out_a;
    repeat (600) begin
      @(negedge clk);
      if (out_a !== sa) n++;
      sa = out_a;
    end
    check1(n >= 2 && n <= 3, 1'b1);
    done("waveform");
    results();
  end
endmodule
